/* logic/snm_fifo.sv */
// Purpose: Small first-in first-out queue with valid/ready on both sides.
// Assumes: DEPTH is a power of two.
// Notes:   in_ready_o low while full; out_valid_o low while empty.
`default_nettype none
module snm_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] buf_reg [DEPTH];
   logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
   logic [AW:0] cnt_reg, cnt_next;
   logic push, pop;

   always_comb begin
      in_ready_o = (cnt_reg != CNT_FULL);
      out_valid_o = (cnt_reg != '0);
      out_data_o = buf_reg[rp_reg];
      push = in_valid_i && in_ready_o;
      pop = out_valid_o && out_ready_i;
      wp_next = push ? wp_reg + 1'b1 : wp_reg;
      rp_next = pop ? rp_reg + 1'b1 : rp_reg;
      cnt_next = cnt_reg;
      if (push && !pop) begin
         cnt_next = cnt_reg + 1'b1;
      end else if (pop && !push) begin
         cnt_next = cnt_reg - 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wp_reg <= '0;
         rp_reg <= '0;
         cnt_reg <= '0;
      end else begin
         wp_reg <= wp_next;
         rp_reg <= rp_next;
         cnt_reg <= cnt_next;
      end
   end

   // Storage, no reset needed
   always_ff @(posedge clk_sys_i) begin
      if (push) begin
         buf_reg[wp_reg] <= in_data_i;
      end
   end
endmodule
`default_nettype wire

/* logic/snm_pkg.sv */
// Purpose: Shared constants and types of the serial memory slave.
// Assumes: One system clock; all bus pins are asynchronous to it.
// Notes:   Field positions refer to the slave address byte or to the synchroniser vector.
`default_nettype none
package snm_pkg;
   // Byte and memory geometry
   localparam int DATA_W = 8;
   localparam int ADDR_W = 13;
   localparam int ADDR_HI_W = 5;
   localparam int MEM_DEPTH = 8192;
   localparam logic [ADDR_W-1:0] ADDR_LAST = 13'h1FFF;
   localparam logic [ADDR_W-1:0] ADDR_FIRST = 13'h0000;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [2:0] BIT_FIRST = 3'h0;

   // Slave address byte layout
   localparam int SEL_W = 3;
   localparam int TYPE_W = 4;
   localparam int SADDR_DIR_BIT = 0;
   localparam int SADDR_SEL_LSB = 1;
   localparam int SADDR_TYPE_LSB = 4;
   localparam logic DIR_WRITE = 1'b0;

   // Write request queue
   localparam int FIFO_DEPTH = 4;
   localparam int WREQ_W = ADDR_W + DATA_W;

   // Synchroniser vector layout
   localparam int PIN_W = 6;
   localparam int PIN_SCL = 0;
   localparam int PIN_SDA = 1;
   localparam int PIN_SEL_LSB = 2;
   localparam int PIN_WP = 5;
   // Bus lines idle high, straps idle low; avoids false edges after reset
   localparam logic [PIN_W-1:0] PIN_RESET = 6'h03;

   typedef enum logic [2:0] {
      SNM_IDLE,
      SNM_RX,
      SNM_RXEND,
      SNM_ACK,
      SNM_TX,
      SNM_MACK,
      SNM_TXWAIT
   } snm_state_t;

   typedef enum logic [1:0] {
      SNM_PH_SADDR,
      SNM_PH_AHI,
      SNM_PH_ALO,
      SNM_PH_DATA
   } snm_phase_t;
endpackage
`default_nettype wire

/* logic/snm_slave.sv */
// Purpose: Two-wire serial slave with an 8192 x 8 byte memory.
// Assumes: Bus pins are oversampled by a 25 MHz system clock.
// Notes:   Write bytes pass a four-entry queue before the array.
`default_nettype none
module snm_slave #(
   // Device type code; value is arbitrary
   parameter logic [3:0] DEV_TYPE = 4'h6
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   // Two-wire bus
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // Straps
   input wire logic [2:0] device_select_pins_i,
   input wire logic wp_i
);
   function automatic logic [snm_pkg::ADDR_W-1:0] addr_inc(
      input logic [snm_pkg::ADDR_W-1:0] a
   );
      if (a == snm_pkg::ADDR_LAST) begin
         addr_inc = snm_pkg::ADDR_FIRST;
      end else begin
         addr_inc = a + 1'b1;
      end
   endfunction

   // Synchronisers and edge history
   logic [snm_pkg::PIN_W-1:0] sync1_reg, sync1_next;
   logic [snm_pkg::PIN_W-1:0] sync2_reg, sync2_next;
   logic scl_prev_reg, scl_prev_next, sda_prev_reg, sda_prev_next;
   logic scl_s, sda_s, wp_s;
   logic [snm_pkg::SEL_W-1:0] sel_s;
   logic scl_rise, scl_fall, bus_start, bus_stop;

   // Serial engine
   snm_pkg::snm_state_t state_reg, state_next;
   snm_pkg::snm_phase_t phase_reg, phase_next;
   logic [2:0] bit_cnt_reg, bit_cnt_next;
   logic [snm_pkg::DATA_W-1:0] shift_reg, shift_next;
   logic [snm_pkg::ADDR_W-1:0] addr_reg, addr_next;
   logic rd_mode_reg, rd_mode_next;
   logic sda_oe_reg, sda_oe_next;
   logic sda_o_reg, sda_o_next;
   logic [snm_pkg::DATA_W-1:0] rx_byte;
   logic [snm_pkg::DATA_W-1:0] tx_byte;

   // Write queue and array port
   logic wq_in_valid, wq_in_ready, wq_out_valid, wq_out_ready;
   logic [snm_pkg::WREQ_W-1:0] wq_in_data, wq_out_data;
   logic rd_req;
   logic mem_we;
   logic [snm_pkg::ADDR_W-1:0] mem_waddr;
   logic [snm_pkg::DATA_W-1:0] mem_wdata;
   logic [snm_pkg::DATA_W-1:0] rd_data_reg, rd_data_next;
   logic [snm_pkg::DATA_W-1:0] mem_reg [snm_pkg::MEM_DEPTH];

   // Pin synchronisation and bus conditions
   always_comb begin
      sync1_next = {wp_i, device_select_pins_i, sda_i, scl_i};
      sync2_next = sync1_reg;
      scl_s = sync2_reg[snm_pkg::PIN_SCL];
      sda_s = sync2_reg[snm_pkg::PIN_SDA];
      wp_s = sync2_reg[snm_pkg::PIN_WP];
      sel_s = sync2_reg[snm_pkg::PIN_SEL_LSB +: snm_pkg::SEL_W];
      scl_prev_next = scl_s;
      sda_prev_next = sda_s;
      scl_rise = scl_s && !scl_prev_reg;
      scl_fall = !scl_s && scl_prev_reg;
      bus_start = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
      bus_stop = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync1_reg <= snm_pkg::PIN_RESET;
         sync2_reg <= snm_pkg::PIN_RESET;
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         scl_prev_reg <= scl_prev_next;
         sda_prev_reg <= sda_prev_next;
      end
   end

   // Serial engine
   always_comb begin
      state_next = state_reg;
      phase_next = phase_reg;
      bit_cnt_next = bit_cnt_reg;
      shift_next = shift_reg;
      addr_next = addr_reg;
      rd_mode_next = rd_mode_reg;
      sda_oe_next = sda_oe_reg;
      sda_o_next = 1'b0;
      wq_in_valid = 1'b0;
      wq_in_data = {addr_reg, shift_reg};
      rx_byte = shift_reg;
      tx_byte = rd_data_reg;
      rd_req = (state_reg == snm_pkg::SNM_TXWAIT) ||
               (state_reg == snm_pkg::SNM_ACK && rd_mode_reg);
      if (bus_stop) begin
         state_next = snm_pkg::SNM_IDLE;
         sda_oe_next = 1'b0;
      end else if (bus_start) begin
         state_next = snm_pkg::SNM_RX;
         phase_next = snm_pkg::SNM_PH_SADDR;
         bit_cnt_next = snm_pkg::BIT_FIRST;
         rd_mode_next = 1'b0;
         sda_oe_next = 1'b0;
      end else begin
         case (state_reg)
            snm_pkg::SNM_RX: begin
               if (scl_rise) begin
                  shift_next = {shift_reg[snm_pkg::DATA_W-2:0], sda_s};
                  bit_cnt_next = bit_cnt_reg + 1'b1;
                  if (bit_cnt_reg == snm_pkg::BIT_LAST) begin
                     state_next = snm_pkg::SNM_RXEND;
                  end
               end
            end
            snm_pkg::SNM_RXEND: begin
               if (scl_fall) begin
                  state_next = snm_pkg::SNM_ACK;
                  sda_oe_next = 1'b1;
                  case (phase_reg)
                     snm_pkg::SNM_PH_SADDR: begin
                        if (rx_byte[snm_pkg::SADDR_TYPE_LSB +:
                                    snm_pkg::TYPE_W] != DEV_TYPE ||
                            rx_byte[snm_pkg::SADDR_SEL_LSB +:
                                    snm_pkg::SEL_W] != sel_s) begin
                           state_next = snm_pkg::SNM_IDLE;
                           sda_oe_next = 1'b0;
                        end else if (rx_byte[snm_pkg::SADDR_DIR_BIT] ==
                                     snm_pkg::DIR_WRITE) begin
                           phase_next = snm_pkg::SNM_PH_AHI;
                        end else begin
                           rd_mode_next = 1'b1;
                        end
                     end
                     snm_pkg::SNM_PH_AHI: begin
                        addr_next[snm_pkg::ADDR_W-1:snm_pkg::DATA_W] =
                           rx_byte[snm_pkg::ADDR_HI_W-1:0];
                        phase_next = snm_pkg::SNM_PH_ALO;
                     end
                     snm_pkg::SNM_PH_ALO: begin
                        addr_next[snm_pkg::DATA_W-1:0] = rx_byte;
                        phase_next = snm_pkg::SNM_PH_DATA;
                     end
                     default: begin
                        if (wp_s) begin
                           addr_next = addr_inc(addr_reg);
                        end else if (wq_in_ready) begin
                           wq_in_valid = 1'b1;
                           addr_next = addr_inc(addr_reg);
                        end else begin
                           state_next = snm_pkg::SNM_IDLE;
                           sda_oe_next = 1'b0;
                        end
                     end
                  endcase
               end
            end
            snm_pkg::SNM_ACK: begin
               if (scl_fall) begin
                  bit_cnt_next = snm_pkg::BIT_FIRST;
                  if (rd_mode_reg) begin
                     shift_next = tx_byte;
                     sda_oe_next = !tx_byte[snm_pkg::DATA_W-1];
                     state_next = snm_pkg::SNM_TX;
                  end else begin
                     sda_oe_next = 1'b0;
                     state_next = snm_pkg::SNM_RX;
                  end
               end
            end
            snm_pkg::SNM_TX: begin
               if (scl_fall) begin
                  bit_cnt_next = bit_cnt_reg + 1'b1;
                  shift_next = {shift_reg[snm_pkg::DATA_W-2:0], 1'b0};
                  if (bit_cnt_reg == snm_pkg::BIT_LAST) begin
                     sda_oe_next = 1'b0;
                     addr_next = addr_inc(addr_reg);
                     state_next = snm_pkg::SNM_MACK;
                  end else begin
                     sda_oe_next = !shift_reg[snm_pkg::DATA_W-2];
                  end
               end
            end
            snm_pkg::SNM_MACK: begin
               if (scl_rise) begin
                  if (sda_s) begin
                     state_next = snm_pkg::SNM_IDLE;
                  end else begin
                     state_next = snm_pkg::SNM_TXWAIT;
                  end
               end
            end
            snm_pkg::SNM_TXWAIT: begin
               if (scl_fall) begin
                  bit_cnt_next = snm_pkg::BIT_FIRST;
                  shift_next = tx_byte;
                  sda_oe_next = !tx_byte[snm_pkg::DATA_W-1];
                  state_next = snm_pkg::SNM_TX;
               end
            end
            default: begin
               sda_oe_next = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_reg <= snm_pkg::SNM_IDLE;
         phase_reg <= snm_pkg::SNM_PH_SADDR;
         bit_cnt_reg <= snm_pkg::BIT_FIRST;
         shift_reg <= '0;
         addr_reg <= snm_pkg::ADDR_FIRST;
         rd_mode_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
         sda_o_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         phase_reg <= phase_next;
         bit_cnt_reg <= bit_cnt_next;
         shift_reg <= shift_next;
         addr_reg <= addr_next;
         rd_mode_reg <= rd_mode_next;
         sda_oe_reg <= sda_oe_next;
         sda_o_reg <= sda_o_next;
      end
   end

   assign sda_o = sda_o_reg;
   assign sda_oe_o = sda_oe_reg;

   snm_fifo #(
      .WIDTH(snm_pkg::WREQ_W),
      .DEPTH(snm_pkg::FIFO_DEPTH)
   ) u_wq (
      .clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i),
      .in_valid_i(wq_in_valid),
      .in_ready_o(wq_in_ready),
      .in_data_i(wq_in_data),
      .out_valid_o(wq_out_valid),
      .out_ready_i(wq_out_ready),
      .out_data_o(wq_out_data)
   );

   // Single array port, reads take priority over draining
   always_comb begin
      wq_out_ready = !rd_req;
      mem_we = wq_out_valid && wq_out_ready;
      mem_waddr = wq_out_data[snm_pkg::WREQ_W-1:snm_pkg::DATA_W];
      mem_wdata = wq_out_data[snm_pkg::DATA_W-1:0];
      rd_data_next = rd_req ? mem_reg[addr_reg] : rd_data_reg;
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rd_data_reg <= '0;
      end else begin
         rd_data_reg <= rd_data_next;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (mem_we) begin
         mem_reg[mem_waddr] <= mem_wdata;
      end
   end
endmodule
`default_nettype wire

/* sim/snm_master_model.sv */
// Purpose: Behavioural two-wire bus master.
// Assumes: Pulled-up data line; one bit lasts 16 clocks.
// Notes:   Tasks are called by the bench one at a time.
`default_nettype none
module snm_master_model (
   // Clock
   input wire logic clk_sys_i,
   // Bus
   input wire logic sda_i,
   output var logic scl_o,
   output var logic sda_oe_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask
   task automatic bus_start();
      sda_oe_o <= 1'b0;
      tick(4);
      scl_o <= 1'b1;
      tick(4);
      sda_oe_o <= 1'b1;
      tick(4);
      scl_o <= 1'b0;
      tick(4);
   endtask
   task automatic bus_stop();
      sda_oe_o <= 1'b1;
      tick(4);
      scl_o <= 1'b1;
      tick(4);
      sda_oe_o <= 1'b0;
      tick(8);
   endtask
   task automatic bit_io(input logic b, output logic r);
      sda_oe_o <= !b;
      tick(4);
      scl_o <= 1'b1;
      tick(8);
      r = sda_i;
      scl_o <= 1'b0;
      tick(4);
   endtask
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(b[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask
   task automatic get_byte(input logic ack, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
      bit_io(!ack, r);
   endtask
endmodule
`default_nettype wire

/* sim/snm_slave_asserts.sv */
// Purpose: Port checks for the two-wire memory slave.
// Assumes: Bus pins are quiet around system clock edges.
// Notes:   Bound to the slave; watches its ports only.
`default_nettype none
module snm_slave_asserts #(
   parameter logic [3:0] DEV_TYPE = 4'h6
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   // Bus and straps
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic [2:0] device_select_pins_i,
   input wire logic wp_i
);
   logic scl_reg, sda_reg, is_start, is_stop, rise;
   logic [3:0] rise_cnt_reg, rise_cnt_next;
   logic [7:0] sa_reg, sa_next;
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rstn_i);
   assign rise = !scl_reg && scl_i;
   assign is_start = scl_i && scl_reg && sda_reg && !sda_i;
   assign is_stop = scl_i && scl_reg && !sda_reg && sda_i;
   // Rising clocks since start or stop; first eight hold the address
   always_comb begin
      rise_cnt_next = rise_cnt_reg;
      sa_next = sa_reg;
      if (rise && rise_cnt_reg < 4'h8) begin
         sa_next = {sa_reg[6:0], sda_i};
      end
      if (is_start || is_stop) begin
         rise_cnt_next = 4'h0;
      end else if (rise && rise_cnt_reg != 4'hF) begin
         rise_cnt_next = rise_cnt_reg + 4'h1;
      end
   end
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
         rise_cnt_reg <= 4'h0;
         sa_reg <= 8'h00;
      end else begin
         scl_reg <= scl_i;
         sda_reg <= sda_i;
         rise_cnt_reg <= rise_cnt_next;
         sa_reg <= sa_next;
      end
   end
   property p_low; sda_oe_o |-> sda_o == 1'b0; endproperty
   a_low: assert property (p_low)
      else $error("data line driven high");
   property p_edge;
      $changed(sda_oe_o) |-> !$past(scl_i, 2) && $past(scl_i, 5);
   endproperty
   a_edge: assert property (p_edge)
      else $error("drive changed away from falling clock");
   property p_quiet; sda_oe_o |-> rise_cnt_reg >= 4'h8; endproperty
   a_quiet: assert property (p_quiet)
      else $error("drive during slave address");
   sequence s_ack; $rose(sda_oe_o) && rise_cnt_reg == 4'h8; endsequence
   property p_match;
      s_ack |-> sa_reg[3:1] == device_select_pins_i
         && sa_reg[7:4] == DEV_TYPE;
   endproperty
   a_match: assert property (p_match)
      else $error("ack for other device");
   property p_hold; s_ack |-> sda_oe_o [*8]; endproperty
   a_hold: assert property (p_hold)
      else $error("ack too short");
   property p_wr_rel;
      s_ack ##0 sa_reg[0] == 1'b0 |-> ##[8:40] !sda_oe_o;
   endproperty
   a_wr_rel: assert property (p_wr_rel)
      else $error("ack not released in write");
   property p_stop; is_stop |=> !sda_oe_o [*8]; endproperty
   a_stop: assert property (p_stop)
      else $error("drive after stop");
   property p_start; is_start |=> !sda_oe_o [*8]; endproperty
   a_start: assert property (p_start)
      else $error("drive after start");
   c_start: cover property (is_start);
   c_ack: cover property (s_ack);
   c_stop: cover property (is_stop);
endmodule
bind snm_slave snm_slave_asserts #(.DEV_TYPE(DEV_TYPE)) u_snm_asserts (
   .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .scl_i(scl_i), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe_o(sda_oe_o),
   .device_select_pins_i(device_select_pins_i), .wp_i(wp_i));
`default_nettype wire

/* sim/testbench.sv */
// Purpose: Self-checking bench for the two-wire memory slave.
// Assumes: Master model drives the bus; line pulled up here.
// Notes:   Memory is not reset, so reads follow writes.
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [3:0] TYPE = 4'h6;
   logic clk_sys_i, rstn_i, scl, sda, m_oe, sda_o, sda_oe, wp;
   logic [2:0] sel;
   logic [7:0] d;
   logic ack;
   int n_mismatch = 0;
   int compares = 0;
   assign sda = (sda_oe ? sda_o : 1'b1) & !m_oe;
   snm_slave #(.DEV_TYPE(TYPE)) u_snm_slave (.clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe_o(sda_oe), .device_select_pins_i(sel), .wp_i(wp));
   snm_master_model u_master (.clk_sys_i(clk_sys_i), .sda_i(sda),
      .scl_o(scl), .sda_oe_o(m_oe));
   task automatic final_report();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic sel_byte(input logic rd);
      u_master.bus_start();
      u_master.put_byte({TYPE, sel, rd}, ack);
      chk({7'h00, ack}, 8'h01);
   endtask
   task automatic hdr(input logic [15:0] a);
      sel_byte(1'b0);
      u_master.put_byte(a[15:8], ack);
      chk({7'h00, ack}, 8'h01);
      u_master.put_byte(a[7:0], ack);
      chk({7'h00, ack}, 8'h01);
   endtask
   task automatic wr(input logic [7:0] v);
      u_master.put_byte(v, ack);
      chk({7'h00, ack}, 8'h01);
   endtask
   task automatic t_seq();
      hdr(16'h0005);
      wr(8'h11);
      wr(8'h22);
      wr(8'h33);
      wr(8'h44);
      hdr(16'h0005);
      sel_byte(1'b1);
      chk({6'h00, sda_oe, sda_o}, 8'h02);
      u_master.get_byte(1'b1, d);
      chk(d, 8'h11);
      u_master.get_byte(1'b1, d);
      chk(d, 8'h22);
      u_master.get_byte(1'b0, d);
      chk(d, 8'h33);
      chk({7'h00, sda_oe}, 8'h00);
      u_master.bus_stop();
      sel_byte(1'b1);
      u_master.get_byte(1'b0, d);
      chk(d, 8'h44);
      u_master.bus_stop();
   endtask
   task automatic t_wrap();
      hdr(16'hFFFF);
      wr(8'hA5);
      wr(8'h5A);
      u_master.bus_stop();
      hdr(16'h1FFF);
      sel_byte(1'b1);
      u_master.get_byte(1'b1, d);
      chk(d, 8'hA5);
      u_master.get_byte(1'b0, d);
      chk(d, 8'h5A);
      u_master.bus_stop();
   endtask
   task automatic t_protect();
      wp <= 1'b1;
      hdr(16'h0005);
      wr(8'h00);
      u_master.bus_stop();
      wp <= 1'b0;
      hdr(16'h0005);
      sel_byte(1'b1);
      u_master.get_byte(1'b0, d);
      chk(d, 8'h11);
      u_master.bus_stop();
   endtask
   task automatic t_abort();
      hdr(16'h0006);
      for (int i = 0; i < 4; i++) u_master.bit_io(1'b0, ack);
      hdr(16'h0007);
      for (int i = 0; i < 4; i++) u_master.bit_io(1'b0, ack);
      u_master.bus_stop();
      hdr(16'h0006);
      sel_byte(1'b1);
      u_master.get_byte(1'b1, d);
      chk(d, 8'h22);
      u_master.get_byte(1'b0, d);
      chk(d, 8'h33);
      u_master.bus_stop();
   endtask
   task automatic t_select();
      sel <= 3'h5;
      for (int s = 0; s < 8; s++) begin
         u_master.bus_start();
         u_master.put_byte({TYPE, s[2:0], 1'b0}, ack);
         u_master.bus_stop();
         chk({7'h00, ack}, {7'h00, s == 5});
      end
      u_master.bus_start();
      u_master.put_byte({~TYPE, 3'h5, 1'b0}, ack);
      u_master.bus_stop();
      chk({7'h00, ack}, 8'h00);
      sel <= 3'h0;
   endtask
   initial begin
      clk_sys_i = 1'b0;
      forever #20 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      rstn_i = 1'b0;
      sel = 3'h0;
      wp = 1'b0;
      repeat (5) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      t_seq();
      t_wrap();
      t_protect();
      t_abort();
      t_select();
      final_report();
   end
   initial begin
      repeat (60000) @(posedge clk_sys_i);
      n_mismatch++;
      final_report();
   end
endmodule
`default_nettype wire
